// ### hdl/channel_and_vco_divide_select.sv
// Behaviour
// - stage-2 low time is low field plus one
// - stage-2 high time is high field plus one
// - one register holds both 4-bit phase offsets
// - stage-2 bypass halts counting, passes input through
// - stage-1 bypass halts counting, passes input through
// - sync-ignore clear means dividers obey chip sync
// - force bit sets output level with sync-ignore
// - stage-2 starts at its start-level bit
// - stage-1 starts at its start-level bit
// - duty correction on unless disable bit set
// - vco codes 0-4 divide 2-6, others static
// - clock-input power-down stops vco and channel
// - sync holds dividers static, release restarts them
// - writes buffered, update bit loads active set
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module channel_and_vco_divide_select
  import chdiv_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [DATA_W-1:0] writedata,
  output logic      [DATA_W-1:0] readdata,
  output logic                   waitrequest,
  // chip-level sync, active low
  input  wire logic              sync_n,
  // clock outputs and clock-input power-down status
  output logic                   vco_div_out,
  output logic                   ch3_out,
  output logic                   clk_input_pd
);

  // one step of a low/high sub-divider: returns {level, count}
  function automatic logic [4:0] sub_step(
    input logic       lvl,
    input logic [3:0] cnt,
    input logic [7:0] cyc
  );
    logic [3:0] lim;
    lim = lvl ? cyc[3:0] : cyc[7:NIB_HI_LSB];
    if (cnt == lim) begin
      sub_step = {~lvl, 4'h0};
    end else begin
      sub_step = {lvl, cnt + 4'h1};
    end
  endfunction

  bus_state_t        bus_q;
  logic [IDX_W-1:0]  idx;
  logic [7:0]        rd_mux;
  logic              wr_go;
  logic [7:0]        buf_cyc31_q, buf_cyc32_q, buf_phase_q;
  logic [5:0]        buf_ctrl_q;
  logic              buf_dcc_q, buf_clkpd_q;
  logic [2:0]        buf_vco_q;
  logic [7:0]        act_cyc31_q, act_cyc32_q, act_phase_q;
  logic [5:0]        act_ctrl_q;
  logic              act_dcc_q, act_clkpd_q;
  logic [2:0]        act_vco_q;
  logic              upd_q;
  logic [2:0]        vcnt_q;
  logic [2:0]        vlast;
  logic              vco_static;
  logic              vco_q, vco_prev_q;
  logic              sync_hold;
  logic              halt1, halt2;
  logic              s1_lvl_q, s2_lvl_q;
  logic [3:0]        s1_cnt_q, s2_cnt_q;
  logic              s1_out, s1_prev_q, s2_out, raw_prev_q;
  logic              forced;
  logic [PER_W-1:0]  pcnt_q, per_q;
  logic              dcc_lvl;
  logic              ch3_q;
  logic [DATA_W-1:0] readdata_q;

  // bus handshake: one wait cycle per access
  assign idx         = address[ADDR_W-1:2];
  assign waitrequest = (read | write) & (bus_q == BUS_IDLE);
  assign wr_go       = write & (bus_q == BUS_ANS);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_q <= BUS_IDLE;
    end else begin
      case (bus_q)
        BUS_IDLE: begin
          if (read | write) begin
            bus_q <= BUS_ANS;
          end
        end
        BUS_ANS:  bus_q <= BUS_IDLE;
        default:  bus_q <= BUS_IDLE;
      endcase
    end
  end

  // read mux shows the buffered set; update bit reads zero
  always_comb begin
    rd_mux = 8'h00;
    if (idx == CYC31_IDX) begin
      rd_mux = buf_cyc31_q;
    end else if (idx == PHASE_IDX) begin
      rd_mux = buf_phase_q;
    end else if (idx == CYC32_IDX) begin
      rd_mux = buf_cyc32_q;
    end else if (idx == CTRL_IDX) begin
      rd_mux = {2'b00, buf_ctrl_q};
    end else if (idx == DCC_IDX) begin
      rd_mux = {7'h00, buf_dcc_q};
    end else if (idx == VCO_IDX) begin
      rd_mux = {5'h00, buf_vco_q};
    end else if (idx == CLKIN_IDX) begin
      rd_mux = {3'h0, buf_clkpd_q, 4'h0};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readdata_q <= '0;
    end else if (read && bus_q == BUS_IDLE) begin
      readdata_q <= {24'h000000, rd_mux};
    end
  end
  assign readdata = readdata_q;

  // buffer registers take software writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      buf_cyc31_q <= CYC_RST;
      buf_cyc32_q <= CYC_RST;
      buf_phase_q <= PHASE_RST;
      buf_ctrl_q  <= CTRL_RST;
      buf_dcc_q   <= DCC_RST;
      buf_vco_q   <= VCO_RST;
      buf_clkpd_q <= CLKPD_RST;
    end else if (wr_go) begin
      if (idx == CYC31_IDX) begin
        buf_cyc31_q <= writedata[7:0];
      end else if (idx == PHASE_IDX) begin
        buf_phase_q <= writedata[7:0];
      end else if (idx == CYC32_IDX) begin
        buf_cyc32_q <= writedata[7:0];
      end else if (idx == CTRL_IDX) begin
        buf_ctrl_q <= writedata[5:0];
      end else if (idx == DCC_IDX) begin
        buf_dcc_q <= writedata[DCC_BIT];
      end else if (idx == VCO_IDX) begin
        buf_vco_q <= writedata[2:0];
      end else if (idx == CLKIN_IDX) begin
        buf_clkpd_q <= writedata[CLKPD_BIT];
      end
    end
  end

  // update strobe clears itself after one cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      upd_q <= 1'b0;
    end else begin
      upd_q <= wr_go && idx == UPDATE_IDX
               && writedata[UPDATE_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      act_cyc31_q <= CYC_RST;
      act_cyc32_q <= CYC_RST;
      act_phase_q <= PHASE_RST;
      act_ctrl_q  <= CTRL_RST;
      act_dcc_q   <= DCC_RST;
      act_vco_q   <= VCO_RST;
      act_clkpd_q <= CLKPD_RST;
    end else if (upd_q) begin
      act_cyc31_q <= buf_cyc31_q;
      act_cyc32_q <= buf_cyc32_q;
      act_phase_q <= buf_phase_q;
      act_ctrl_q  <= buf_ctrl_q;
      act_dcc_q   <= buf_dcc_q;
      act_vco_q   <= buf_vco_q;
      act_clkpd_q <= buf_clkpd_q;
    end
  end
  assign clk_input_pd = act_clkpd_q;

  // vco_divide_select: period code+2, high for the lower half
  assign vco_static = act_vco_q >= VCO_STATIC_MIN;
  assign vlast      = act_vco_q + 3'h1;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vcnt_q <= 3'h0;
      vco_q  <= 1'b0;
    end else if (act_clkpd_q || vco_static) begin
      vcnt_q <= 3'h0;
      vco_q  <= 1'b0;
    end else begin
      vcnt_q <= (vcnt_q >= vlast) ? 3'h0 : vcnt_q + 3'h1;
      vco_q  <= (vcnt_q >= vlast)
                || ({vcnt_q, 1'b0} + 4'h2 < {1'b0, vlast} + 4'h1);
    end
  end
  assign vco_div_out = vco_q;

  // sync and power-down hold dividers at their start level
  assign sync_hold = ~sync_n & ~act_ctrl_q[NOSYNC_BIT];
  assign halt1 = sync_hold | act_clkpd_q
                 | act_ctrl_q[BYP1_BIT];
  assign halt2 = sync_hold | act_clkpd_q
                 | act_ctrl_q[BYP2_BIT];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vco_prev_q <= 1'b0;
      s1_prev_q  <= 1'b0;
      raw_prev_q <= 1'b0;
    end else begin
      vco_prev_q <= vco_q;
      s1_prev_q  <= s1_out;
      raw_prev_q <= s2_out;
    end
  end

  // stage 1 counts rising edges of the vco_divide_select output
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_lvl_q <= 1'b0;
      s1_cnt_q <= 4'h0;
    end else if (halt1) begin
      s1_lvl_q <= act_ctrl_q[START1_BIT];
      s1_cnt_q <= 4'h0;
    end else if (vco_q && !vco_prev_q) begin
      {s1_lvl_q, s1_cnt_q} <= sub_step(s1_lvl_q, s1_cnt_q, act_cyc31_q);
    end
  end
  assign s1_out = act_ctrl_q[BYP1_BIT] ? vco_q : s1_lvl_q;

  // stage 2 counts rising edges of stage 1
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s2_lvl_q <= 1'b0;
      s2_cnt_q <= 4'h0;
    end else if (halt2) begin
      s2_lvl_q <= act_ctrl_q[START2_BIT];
      s2_cnt_q <= 4'h0;
    end else if (s1_out && !s1_prev_q) begin
      {s2_lvl_q, s2_cnt_q} <= sub_step(s2_lvl_q, s2_cnt_q,
                                       act_cyc32_q);
    end
  end
  assign s2_out = act_ctrl_q[BYP2_BIT] ? s1_out : s2_lvl_q;

  // duty correction: measure period, output high for half of it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pcnt_q <= '0;
      per_q  <= '0;
    end else if (s2_out && !raw_prev_q) begin
      pcnt_q <= '0;
      per_q  <= pcnt_q + 12'h001;
    end else if (pcnt_q != '1) begin
      pcnt_q <= pcnt_q + 12'h001;
    end
  end
  assign dcc_lvl = ({1'b0, pcnt_q} + 13'h0001) * 2 <= {1'b0, per_q} + 13'h0001;

  assign forced = act_ctrl_q[NOSYNC_BIT] & act_ctrl_q[FORCE_BIT];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ch3_q <= 1'b0;
    end else if (act_clkpd_q) begin
      ch3_q <= 1'b0;
    end else if (forced) begin
      ch3_q <= 1'b1;
    end else if (!act_dcc_q && per_q > 12'h001) begin
      ch3_q <= dcc_lvl;
    end else begin
      ch3_q <= s2_out;
    end
  end
  assign ch3_out = ch3_q;

  low_time_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(s2_lvl_q) && !$past(halt2)
      |-> $past(s2_cnt_q) == $past(act_cyc32_q[7:4]))
    else $error("stage 2 low time wrong");

  high_time_a: assert property (@(posedge clk) disable iff (!rstn)
    $fell(s2_lvl_q) && !$past(halt2)
      |-> $past(s2_cnt_q) == $past(act_cyc32_q[3:0]))
    else $error("stage 2 high time wrong");

  // the bypass bit may clear at the next update, so route is checked now
  byp2_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    act_ctrl_q[BYP2_BIT] |-> s2_out == s1_out ##1 s2_cnt_q == 4'h0)
    else $error("stage 2 bypass not holding");

  byp1_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    act_ctrl_q[BYP1_BIT] |-> s1_out == vco_q ##1 s1_cnt_q == 4'h0)
    else $error("stage 1 bypass not holding");

  sync_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    !sync_n && !act_ctrl_q[NOSYNC_BIT] |=> s1_cnt_q == 4'h0
      && s1_lvl_q == $past(act_ctrl_q[START1_BIT]))
    else $error("divider not held by sync");

  force_out_a: assert property (@(posedge clk) disable iff (!rstn)
    forced && !act_clkpd_q |=> ch3_q)
    else $error("forced level missing");

  start_lvl_a: assert property (@(posedge clk) disable iff (!rstn)
    halt2 |=> s2_lvl_q == $past(act_ctrl_q[START2_BIT]))
    else $error("stage 2 start level wrong");

  vco_static_a: assert property (@(posedge clk) disable iff (!rstn)
    vco_static |=> !vco_q)
    else $error("vco output not static");

  pd_stop_a: assert property (@(posedge clk) disable iff (!rstn)
    act_clkpd_q |=> !vco_q && !ch3_q && s2_cnt_q == 4'h0)
    else $error("power-down not stopping clocks");

  upd_load_a: assert property (@(posedge clk) disable iff (!rstn)
    upd_q |=> act_vco_q == $past(buf_vco_q) && !upd_q)
    else $error("update did not load active set");

  start1_lvl_a: assert property (@(posedge clk) disable iff (!rstn)
    halt1 |=> s1_lvl_q == $past(act_ctrl_q[START1_BIT]))
    else $error("stage 1 start level wrong");

  raw_out_a: assert property (@(posedge clk) disable iff (!rstn)
    act_dcc_q && !forced && !act_clkpd_q |=> ch3_q == $past(s2_out))
    else $error("uncorrected output not raw");

  read_data_a: assert property (@(posedge clk) disable iff (!rstn)
    read && !waitrequest |-> readdata == {24'h000000, $past(rd_mux)})
    else $error("read data not from addressed register");

endmodule
`default_nettype wire

// ### hdl/chdiv_pkg.sv
package chdiv_pkg;
  // bus shape
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 10;
  // register indexes, byte address is four times the index
  localparam logic [IDX_W-1:0] CYC31_IDX  = 10'h19E;
  localparam logic [IDX_W-1:0] PHASE_IDX  = 10'h19F;
  localparam logic [IDX_W-1:0] CYC32_IDX  = 10'h1A0;
  localparam logic [IDX_W-1:0] CTRL_IDX   = 10'h1A1;
  localparam logic [IDX_W-1:0] DCC_IDX    = 10'h1A2;
  localparam logic [IDX_W-1:0] VCO_IDX    = 10'h1E0;
  localparam logic [IDX_W-1:0] CLKIN_IDX  = 10'h1E1;
  localparam logic [IDX_W-1:0] UPDATE_IDX = 10'h232;
  // field positions
  localparam int NIB_HI_LSB = 4;
  localparam int BYP2_BIT   = 5;
  localparam int BYP1_BIT   = 4;
  localparam int NOSYNC_BIT = 3;
  localparam int FORCE_BIT  = 2;
  localparam int START2_BIT = 1;
  localparam int START1_BIT = 0;
  localparam int DCC_BIT    = 0;
  localparam int CLKPD_BIT  = 4;
  localparam int UPDATE_BIT = 0;
  // reset values
  localparam logic [7:0] CYC_RST   = 8'h00;
  localparam logic [7:0] PHASE_RST = 8'h00;
  localparam logic [5:0] CTRL_RST  = 6'h00;
  localparam logic       DCC_RST   = 1'b0;
  localparam logic [2:0] VCO_RST   = 3'h2;
  localparam logic       CLKPD_RST = 1'b0;
  // vco_divide_select coding
  localparam logic [2:0] VCO_DIV_BASE   = 3'h2;
  localparam logic [2:0] VCO_STATIC_MIN = 3'h5;
  // duty correction period counter width
  localparam int PER_W = 12;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ANS  = 1'b1
  } bus_state_t;
endpackage

// ### verif/clk_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module clk_monitor (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // watched output clock
  input  wire logic sig,
  // last run lengths in clk cycles and change count
  output int        hi_len,
  output int        lo_len,
  output int        edges
);
  int   run;
  logic last;
  // a consumer only sees levels, so it times runs between level changes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run    <= 1;
      last   <= 1'b0;
      hi_len <= 0;
      lo_len <= 0;
      edges  <= 0;
    end else if (sig !== last) begin
      if (last) hi_len <= run;
      else lo_len <= run;
      edges <= edges + 1;
      run   <= 1;
      last  <= sig;
    end else begin
      run <= run + 1;
    end
  end
endmodule
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import chdiv_pkg::*;
;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic [ADDR_W-1:0] address = '0;
  logic              read = 1'b0;
  logic              write = 1'b0;
  logic [DATA_W-1:0] writedata = '0;
  logic [DATA_W-1:0] readdata;
  logic              waitrequest;
  logic              sync_n = 1'b1;
  logic              vco_div_out;
  logic              ch3_out;
  logic              clk_input_pd;
  int                vhi, vlo, ved, chi, clo, ced, e0;
  int                miscompares = 0;
  int                num_checks = 0;
  logic [31:0]       rv;
  logic [9:0]        ridx [9] = '{CYC31_IDX, PHASE_IDX, CYC32_IDX, CTRL_IDX,
    DCC_IDX, VCO_IDX, CLKIN_IDX, UPDATE_IDX, 10'h100};
  logic [7:0]        rexp [9] = '{CYC_RST, PHASE_RST, CYC_RST, 8'h00, 8'h00,
    8'h02, 8'h00, 8'h00, 8'h00};
  // cyc31, cyc32, ctrl, dcc-off, high, low with vco at divide by 2
  logic [7:0]        ctab [5][6] = '{'{8'h00, 8'h00, 8'h00, 8'h01, 4, 4},
    '{8'h00, 8'h21, 8'h10, 8'h01, 4, 6}, '{8'h00, 8'h20, 8'h10, 8'h01, 2, 6},
    '{8'h00, 8'h20, 8'h10, 8'h00, 4, 4}, '{8'h00, 8'h00, 8'h20, 8'h01, 2, 2}};
  always #50 clk = ~clk;
  channel_and_vco_divide_select dut (.clk(clk), .rstn(rstn), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .sync_n(sync_n), .vco_div_out(vco_div_out),
    .ch3_out(ch3_out), .clk_input_pd(clk_input_pd));
  clk_monitor m_vco (.clk(clk), .rstn(rstn), .sig(vco_div_out),
    .hi_len(vhi), .lo_len(vlo), .edges(ved));
  clk_monitor m_ch (.clk(clk), .rstn(rstn), .sig(ch3_out),
    .hi_len(chi), .lo_len(clo), .edges(ced));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [9:0] idx, input logic wr,
                     input logic [7:0] d);
    @(posedge clk);
    address   <= {idx, 2'b00};
    read      <= !wr;
    write     <= wr;
    writedata <= {24'h0, d};
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    rv = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic upd();
    bus(UPDATE_IDX, 1'b1, 8'h01);
  endtask
  task automatic test_done();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #(100 * 20000);
    miscompares++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      bus(ridx[i], 1'b0, 8'h00);
      chk(rv, {24'h0, rexp[i]});
    end
    $display("test reset_values done");
    bus(PHASE_IDX, 1'b1, 8'hA5);
    bus(PHASE_IDX, 1'b0, 8'h00);
    chk(rv, 32'hA5);
    bus(VCO_IDX, 1'b1, 8'h00);
    repeat (30) @(posedge clk);
    chk(vhi + vlo, 4);
    for (int c = 0; c < 8; c++) begin
      bus(VCO_IDX, 1'b1, c[7:0]);
      upd();
      repeat (8) @(posedge clk);
      e0 = ved;
      repeat (30) @(posedge clk);
      if (c < 5) begin
        chk(vhi, (c + 3) / 2);
        chk(vlo, (c + 2) - (c + 3) / 2);
      end else begin
        chk(ved, e0);
        chk(vco_div_out, 1'b0);
      end
    end
    $display("test vco_divide done");
    bus(VCO_IDX, 1'b1, 8'h00);
    for (int i = 0; i < 5; i++) begin
      bus(CYC31_IDX, 1'b1, ctab[i][0]);
      bus(CYC32_IDX, 1'b1, ctab[i][1]);
      bus(CTRL_IDX, 1'b1, ctab[i][2]);
      bus(DCC_IDX, 1'b1, ctab[i][3]);
      upd();
      repeat (60) @(posedge clk);
      chk(chi, 32'(ctab[i][4]));
      chk(clo, 32'(ctab[i][5]));
    end
    $display("test channel_ratio done");
    for (int s = 0; s < 2; s++) begin
      bus(CTRL_IDX, 1'b1, {6'h0, s[0], 1'b0});
      bus(CYC32_IDX, 1'b1, 8'h00);
      upd();
      sync_n <= 1'b0;
      repeat (10) @(posedge clk);
      chk(ch3_out, s);
      e0 = ced;
      repeat (20) @(posedge clk);
      chk(ced, e0);
      sync_n <= 1'b1;
      repeat (40) @(posedge clk);
      chk(chi, 32'd4);
      chk(clo, 32'd4);
    end
    bus(CTRL_IDX, 1'b1, 8'h08);
    upd();
    sync_n <= 1'b0;
    repeat (5) @(posedge clk);
    e0 = ced;
    repeat (20) @(posedge clk);
    chk(ced > e0, 1);
    sync_n <= 1'b1;
    bus(CTRL_IDX, 1'b1, 8'h0C);
    upd();
    repeat (10) @(posedge clk);
    chk(ch3_out, 1);
    e0 = ced;
    repeat (20) @(posedge clk);
    chk(ced, e0);
    $display("test sync_force done");
    bus(CLKIN_IDX, 1'b1, 8'h10);
    upd();
    repeat (5) @(posedge clk);
    chk(clk_input_pd, 1);
    chk(ch3_out, 1'b0);
    e0 = ved;
    repeat (20) @(posedge clk);
    chk(ved, e0);
    $display("test power_down done");
    test_done();
  end
endmodule
`default_nettype wire
